// ---- rtl/switch_queue_mirror_throttle_cfg.sv ----
// APB register bank and per-packet decisions for queue map, mirroring and throttle
//
// Operation
// - Egress queue for priority p is map bits 2p+1:2p, priority 7 on top.
// - Map resets to queues 1,0,0,1,2,2,3,3 for priorities 0 to 7.
// - With receive mirroring on, packets received on mirrored ports also go to sniffer, except filtered packets and broadcasts dropped by throttling.
// - With transmit mirroring on, packets sent on mirrored ports also go to sniffer.
// - Filtered-mirror bit sends filtered packets to sniffer only; cleared, never mirrored.
// - Mirrored filtered packets still bump filtered counters and raise drop interrupt.
// - Sniffer port is a one-hot field 7:5; software should set one bit.
// - Mirrored ports field 4:2, one bit per port, any combination allowed.
// - Ingress type 11b enables VLAN-tag destination; other values disable it.
// - Broadcast throttling active only while port enable bit 26, 17 or 8 is set.
// - Allowance is level times 64 bytes per 1.72 ms; level resets to 2.
`include "sqmt_regs.svh"
`default_nettype none

module switch_queue_mirror_throttle_cfg #(
  parameter int INTERVAL_CYCLES = `BT_INTERVAL_CYCLES,
  parameter int NPORTS          = 3
) (
  input  wire logic             clk,         // Switch clock, 20 MHz
  input  wire logic             reset_n,     // Async reset, active low
  input  wire logic             psel,        // APB select
  input  wire logic             penable,     // APB enable
  input  wire logic             pwrite,      // APB direction
  input  wire logic [15:0]      paddr,       // APB byte address
  input  wire logic [31:0]      pwdata,      // APB write data
  output logic                  pready,      // APB ready
  output logic [31:0]           prdata,      // APB read data
  output logic                  pslverr,     // APB error, unmapped or misaligned address
  input  wire sqmt_pkg::rx_pkt_s rx_pkt,     // Received packet event
  input  wire sqmt_pkg::tx_pkt_s tx_pkt,     // Transmitted packet event
  output sqmt_pkg::rx_res_s     rx_res,      // Decision for received packet
  output sqmt_pkg::tx_res_s     tx_res,      // Decision for transmitted packet
  output logic [NPORTS-1:0]     sniffer_sel, // One-hot sniffer port
  output logic [NPORTS-1:0]     tag_dest_en  // VLAN-tag destination per port
);

  // ============================================================
  // Registers
  logic [31:0] priority_queue_map;
  logic [31:0] port_mirroring_cfg;
  logic [31:0] ingress_port_type_cfg;
  logic [31:0] broadcast_throttle_cfg;
  logic [NPORTS-1:0] throttling;

  localparam int IW = $clog2(INTERVAL_CYCLES + 1);

  logic          setup;
  logic          wr_take;
  logic [13:0]   widx;
  logic          hit;
  logic [31:0]   rd_val;

  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite;
  assign widx    = paddr[15:2];

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    case (paddr[15:2])
      14'(`IDX_PRIORITY_QUEUE_MAP):     rd_val = priority_queue_map;
      14'(`IDX_PORT_MIRRORING_CFG):     rd_val = port_mirroring_cfg;
      14'(`IDX_INGRESS_PORT_TYPE_CFG):  rd_val = ingress_port_type_cfg;
      14'(`IDX_BROADCAST_THROTTLE_CFG): rd_val = broadcast_throttle_cfg;
      14'(`IDX_THROTTLE_STATUS):        rd_val = {{(32-NPORTS){1'b0}}, throttling};
      default:                          hit = 1'b0;
    endcase
  end

  // ============================================================
  // APB answer: ready in first access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!hit || (paddr[1:0] != 2'h0));
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ============================================================
  // Register writes
  // reset map
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      priority_queue_map     <= `RST_PRIORITY_QUEUE_MAP;
      port_mirroring_cfg     <= `RST_PORT_MIRRORING_CFG;
      ingress_port_type_cfg  <= `RST_INGRESS_PORT_TYPE_CFG;
      broadcast_throttle_cfg <= `RST_BROADCAST_THROTTLE_CFG;
    end else if (wr_take && !pslverr) begin
      case (widx)
        14'(`IDX_PRIORITY_QUEUE_MAP):
          priority_queue_map <= pwdata & `MSK_PRIORITY_QUEUE_MAP;
        14'(`IDX_PORT_MIRRORING_CFG):
          port_mirroring_cfg <= pwdata & `MSK_PORT_MIRRORING_CFG;
        14'(`IDX_INGRESS_PORT_TYPE_CFG):
          ingress_port_type_cfg <= pwdata & `MSK_INGRESS_PORT_TYPE_CFG;
        14'(`IDX_BROADCAST_THROTTLE_CFG):
          broadcast_throttle_cfg <= pwdata & `MSK_BROADCAST_THROTTLE_CFG;
        default: ;
      endcase
    end
  end

  // ============================================================
  // Field decode
  logic              mir_tx_en;
  logic              mir_rx_en;
  logic              mir_filt_en;
  logic [NPORTS-1:0] mir_ports;
  logic [NPORTS-1:0] sniffer_fld;
  logic [NPORTS-1:0] rx_port_bit;
  logic [NPORTS-1:0] tx_port_bit;
  logic [1:0]        queue_sel;

  assign mir_tx_en   = port_mirroring_cfg[`MIR_TX_EN_BIT];
  assign mir_rx_en   = port_mirroring_cfg[`MIR_RX_EN_BIT];
  assign mir_filt_en = port_mirroring_cfg[`MIR_FILTERED_BIT];
  assign mir_ports   = port_mirroring_cfg[`MIR_PORTS_LSB +: NPORTS];
  assign sniffer_fld = port_mirroring_cfg[`MIR_SNIFFER_LSB +: NPORTS];
  assign rx_port_bit = NPORTS'(1) << rx_pkt.port;
  assign tx_port_bit = NPORTS'(1) << tx_pkt.port;
  assign queue_sel   = priority_queue_map[{rx_pkt.prio, 1'b0} +: 2];

  // ============================================================
  // Broadcast throttle interval
  logic [IW-1:0] ivl_cnt;
  logic          ivl_tick;

  assign ivl_tick = (ivl_cnt == IW'(INTERVAL_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ivl_cnt <= '0;
    end else if (ivl_tick) begin
      ivl_cnt <= '0;
    end else begin
      ivl_cnt <= ivl_cnt + IW'(1);
    end
  end

  // ============================================================
  // Per-port throttle counters and tag mode
  logic [NPORTS-1:0] bt_drop;
  logic [15:0]       bcnt [NPORTS];

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      logic       en;
      logic [7:0] level;
      logic [15:0] allow;
      logic       hit_p;

      assign en    = broadcast_throttle_cfg[p*`BT_PORT_STRIDE + `BT_ENABLE_OFS];
      assign level = broadcast_throttle_cfg[p*`BT_PORT_STRIDE +: 8];
      assign allow = {2'h0, level, 6'h00};
      assign hit_p = rx_pkt.valid && rx_pkt.bcast && rx_port_bit[p];
      assign bt_drop[p] = en && (bcnt[p] > allow);

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          bcnt[p] <= 16'h0000;
        end else if (ivl_tick || !en) begin
          bcnt[p] <= 16'h0000;
        end else if (hit_p && !bt_drop[p]) begin
          bcnt[p] <= bcnt[p] + {5'h00, rx_pkt.len};
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          throttling[p] <= 1'b0;
        end else begin
          throttling[p] <= bt_drop[p];
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          tag_dest_en[p] <= 1'b0;
        end else begin
          tag_dest_en[p] <= (ingress_port_type_cfg[2*p +: 2] == `TAG_DEST_CODE);
        end
      end
    end
  endgenerate

  // ============================================================
  // Packet decisions
  logic rx_mirrored;
  logic rx_bdrop;

  assign rx_mirrored = |(rx_port_bit & mir_ports);
  assign rx_bdrop    = |(rx_port_bit & bt_drop) && rx_pkt.bcast;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_res <= '0;
    end else begin
      rx_res.valid <= rx_pkt.valid;
      rx_res.queue <= queue_sel;
      rx_res.mirror <= rx_pkt.valid && mir_rx_en && rx_mirrored
                       && !rx_pkt.filtered && !rx_bdrop;
      rx_res.sniffer_only <= rx_pkt.valid && mir_rx_en && rx_mirrored
                             && rx_pkt.filtered && mir_filt_en;
      rx_res.filt_cnt_inc <= rx_pkt.valid && rx_pkt.filtered;
      rx_res.drop_irq     <= rx_pkt.valid && (rx_pkt.filtered || rx_bdrop);
      rx_res.bcast_drop   <= rx_pkt.valid && rx_bdrop;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_res <= '0;
    end else begin
      tx_res.valid  <= tx_pkt.valid;
      tx_res.mirror <= tx_pkt.valid && mir_tx_en && |(tx_port_bit & mir_ports);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sniffer_sel <= '0;
    end else begin
      sniffer_sel <= sniffer_fld;
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic map_written;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      map_written <= 1'b0;
    end else if (wr_take && widx == 14'(`IDX_PRIORITY_QUEUE_MAP)) begin
      map_written <= 1'b1;
    end
  end

  sequence s_rx_take;
    rx_pkt.valid;
  endsequence

  sequence s_rx_filtered;
    s_rx_take ##0 rx_pkt.filtered;
  endsequence

  AST_QUEUE_MAP: assert property (
    s_rx_take |=> rx_res.valid && rx_res.queue == $past(queue_sel))
    else $error("egress queue differs from map field");

  AST_MAP_RESET: assert property (
    !map_written |-> priority_queue_map[15:0] == 16'hFA41)
    else $error("priority map lost reset value");

  AST_RX_MIRROR: assert property (
    s_rx_take ##0 (mir_rx_en && rx_mirrored && !rx_pkt.filtered && !rx_bdrop)
      |=> rx_res.mirror)
    else $error("rx mirror copy missing");

  AST_TX_MIRROR: assert property (
    tx_pkt.valid |=> tx_res.mirror == $past(mir_tx_en && |(tx_port_bit & mir_ports)))
    else $error("tx mirror decision wrong");

  AST_FILT_NOMIR: assert property (
    s_rx_filtered ##0 !mir_filt_en |=> !rx_res.sniffer_only && !rx_res.mirror)
    else $error("filtered packet mirrored while disabled");

  AST_FILT_COUNT: assert property (
    s_rx_filtered |=> rx_res.filt_cnt_inc && rx_res.drop_irq)
    else $error("filtered packet not counted");

  AST_SNIFFER: assert property (
    ##1 sniffer_sel == $past(sniffer_fld))
    else $error("sniffer select not following field");

  AST_TAG_DEST: assert property (
    ##1 tag_dest_en[0] == ($past(ingress_port_type_cfg[1:0]) == 2'h3))
    else $error("tag destination enable wrong");

  AST_THROT_OFF: assert property (
    s_rx_take ##0 !broadcast_throttle_cfg[8] && rx_pkt.port == 2'h0 |=> !rx_res.bcast_drop)
    else $error("throttle drop while disabled");

  AST_IVL_RESTART: assert property (
    ivl_tick |=> bcnt[0] == 16'h0000 && ivl_cnt == '0)
    else $error("interval did not restart count");

  sequence s_rx_bcast0;
    s_rx_take ##0 rx_pkt.bcast && rx_pkt.port == 2'h0;
  endsequence

  AST_FILT_SNIFF: assert property (
    s_rx_filtered ##0 mir_filt_en && mir_rx_en && rx_mirrored
      |=> rx_res.sniffer_only && !rx_res.mirror)
    else $error("filtered packet not sent to sniffer only");

  AST_NOMIR_PORT: assert property (
    s_rx_take ##0 rx_pkt.port == 2'h0 && !port_mirroring_cfg[`MIR_PORTS_LSB]
      |=> !rx_res.mirror && !rx_res.sniffer_only)
    else $error("unmirrored port produced a mirror copy");

  AST_TAG_DEST_TOP: assert property (
    ##1 tag_dest_en[NPORTS-1] == ($past(ingress_port_type_cfg[2*(NPORTS-1) +: 2]) == 2'h3))
    else $error("top port tag destination enable wrong");

  AST_THROT_DROP: assert property (
    s_rx_bcast0 ##0 broadcast_throttle_cfg[`BT_ENABLE_OFS]
      && bcnt[0] > {2'h0, broadcast_throttle_cfg[7:0], 6'h00}
      |=> rx_res.bcast_drop && rx_res.drop_irq && !rx_res.mirror)
    else $error("broadcast over allowance not dropped");

  AST_COUNT_HOLD: assert property (
    !ivl_tick && !rx_pkt.valid && broadcast_throttle_cfg[`BT_ENABLE_OFS]
      |=> $stable(bcnt[0]))
    else $error("broadcast count moved without a packet");

  AST_IVL_BOUND: assert property (
    ivl_cnt <= IW'(INTERVAL_CYCLES - 1))
    else $error("interval counter overran its period");

endmodule : switch_queue_mirror_throttle_cfg
`default_nettype wire

// ---- include/sqmt_regs.svh ----
// Register offsets, field positions, reset values and timing for the switch config block
`ifndef SQMT_REGS_SVH
`define SQMT_REGS_SVH

// ============================================================
// Register indices (byte address = index * 4)
`define IDX_PRIORITY_QUEUE_MAP      16'h1845
`define IDX_PORT_MIRRORING_CFG      16'h1846
`define IDX_INGRESS_PORT_TYPE_CFG   16'h1847
`define IDX_BROADCAST_THROTTLE_CFG  16'h1848
`define IDX_THROTTLE_STATUS         16'h1850

// ============================================================
// Reset values
`define RST_PRIORITY_QUEUE_MAP      32'h0000FA41
`define RST_PORT_MIRRORING_CFG      32'h00000000
`define RST_INGRESS_PORT_TYPE_CFG   32'h00000000
`define RST_BROADCAST_THROTTLE_CFG  32'h00080402

// ============================================================
// Writable bit masks
`define MSK_PRIORITY_QUEUE_MAP      32'h0000FFFF
`define MSK_PORT_MIRRORING_CFG      32'h000001FF
`define MSK_INGRESS_PORT_TYPE_CFG   32'h0000003F
`define MSK_BROADCAST_THROTTLE_CFG  32'h07FFFFFF

// ============================================================
// Field positions
`define MIR_TX_EN_BIT       0
`define MIR_RX_EN_BIT       1
`define MIR_PORTS_LSB       2
`define MIR_SNIFFER_LSB     5
`define MIR_FILTERED_BIT    8
`define TAG_DEST_CODE       2'h3
`define BT_PORT_STRIDE      9
`define BT_ENABLE_OFS       8
`define BT_UNIT_SHIFT       6

// ============================================================
// Timing
`define CLK_PERIOD_NS       50
`define BT_INTERVAL_NS      1720000
`define BT_INTERVAL_CYCLES  (`BT_INTERVAL_NS / `CLK_PERIOD_NS)

`endif

// ---- include/sqmt_pkg.sv ----
// Types shared by the switch queue, mirroring and throttle block
`default_nettype none
package sqmt_pkg;

  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    logic [2:0]  prio;
    logic        filtered;
    logic        bcast;
    logic [10:0] len;
  } rx_pkt_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  queue;
    logic        mirror;
    logic        sniffer_only;
    logic        filt_cnt_inc;
    logic        drop_irq;
    logic        bcast_drop;
  } rx_res_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
  } tx_pkt_s;

  typedef struct packed {
    logic        valid;
    logic        mirror;
  } tx_res_s;

endpackage : sqmt_pkg
`default_nettype wire

// ---- verification/switch_queue_mirror_throttle_cfg_tb_top.sv ----
// Self-checking testbench for the switch queue, mirroring and throttle block
`include "sqmt_regs.svh"
`default_nettype none
module switch_queue_mirror_throttle_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IVL = 2000;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [15:0]       paddr;
  logic [31:0]       pwdata, prdata;
  sqmt_pkg::rx_pkt_s rx_pkt;
  sqmt_pkg::tx_pkt_s tx_pkt;
  sqmt_pkg::rx_res_s rx_res;
  sqmt_pkg::tx_res_s tx_res;
  logic [2:0]        sniffer_sel, tag_dest_en;
  int                fails = 0, checks = 0, cyc = 0;

  switch_queue_mirror_throttle_cfg #(.INTERVAL_CYCLES(IVL), .NPORTS(3))
    switch_queue_mirror_throttle_cfg_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .rx_res(rx_res),
    .tx_res(tx_res), .sniffer_sel(sniffer_sel), .tag_dest_en(tag_dest_en));

  // ============================================================
  // Clock, timeout and shared tasks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] ad(input logic [15:0] i);
    return {i[13:0], 2'b00};
  endfunction : ad

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk(n, 32'h1, "apb wait states");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, 32'h0, "read error");
  endtask : rd

  // Flags are mirror, sniffer_only, filt_cnt_inc, drop_irq, bcast_drop
  task automatic rx(input logic [1:0] p, input logic [2:0] pr, input logic f, input logic b,
                    input logic [10:0] l, input logic [1:0] q, input logic [4:0] fl);
    sqmt_pkg::rx_res_s x;
    @(posedge clk);
    rx_pkt <= '{1'b1, p, pr, f, b, l};
    @(posedge clk);
    rx_pkt <= '0;
    #1;
    x = rx_res;
    if (fl[1]) x.queue = q;
    chk({24'h0, x}, {24'h0, 1'b1, q, fl}, "rx result");
  endtask : rx

  task automatic tx(input logic [1:0] p, input logic m);
    @(posedge clk);
    tx_pkt <= '{1'b1, p};
    @(posedge clk);
    tx_pkt <= '0;
    #1;
    chk({30'h0, tx_res}, {30'h0, 1'b1, m}, "tx result");
  endtask : tx

  // ============================================================
  // Scenarios
  task automatic t_queue();
    logic [15:0] m [2] = '{16'hFA41, 16'h1BE4};
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(ad(`IDX_PRIORITY_QUEUE_MAP), {16'h0, m[1]});
      for (int p = 0; p < 8; p++) rx(2'h0, 3'(p), 1'b0, 1'b0, 11'h40, m[k][2*p+:2], 5'h0);
    end
    $display("test queue done");
  endtask : t_queue

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(ad(`IDX_PRIORITY_QUEUE_MAP), 32'h00001BE4);
    rd(ad(`IDX_PORT_MIRRORING_CFG), 32'h00000000);
    rd(ad(`IDX_INGRESS_PORT_TYPE_CFG), 32'h00000000);
    rd(ad(`IDX_BROADCAST_THROTTLE_CFG), 32'h00080402);
    apb(1'b0, 16'h6000, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    wr(ad(`IDX_PRIORITY_QUEUE_MAP), 32'hFFFFFFFF);
    rd(ad(`IDX_PRIORITY_QUEUE_MAP), 32'h0000FFFF);
    apb(1'b1, ad(`IDX_PRIORITY_QUEUE_MAP) | 16'h0002, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "misaligned error");
    rd(ad(`IDX_PRIORITY_QUEUE_MAP), 32'h0000FFFF);
    $display("test registers done");
  endtask : t_regs

  task automatic t_mirror();
    wr(ad(`IDX_PORT_MIRRORING_CFG), 32'h0000008A);
    repeat (2) @(posedge clk);
    chk({29'h0, sniffer_sel}, 32'h4, "sniffer select");
    rx(2'h1, 3'h0, 1'b0, 1'b0, 11'h40, 2'h3, 5'h10);
    rx(2'h0, 3'h0, 1'b0, 1'b0, 11'h40, 2'h3, 5'h00);
    tx(2'h1, 1'b0);
    rx(2'h1, 3'h0, 1'b1, 1'b0, 11'h40, 2'h3, 5'h06);
    wr(ad(`IDX_PORT_MIRRORING_CFG), 32'h00000157);
    repeat (2) @(posedge clk);
    chk({29'h0, sniffer_sel}, 32'h2, "sniffer select");
    rx(2'h1, 3'h0, 1'b0, 1'b0, 11'h40, 2'h3, 5'h00);
    rx(2'h2, 3'h0, 1'b0, 1'b0, 11'h40, 2'h3, 5'h10);
    tx(2'h0, 1'b1);
    tx(2'h1, 1'b0);
    rx(2'h0, 3'h0, 1'b1, 1'b0, 11'h40, 2'h3, 5'h0E);
    $display("test mirror done");
  endtask : t_mirror

  task automatic t_tag();
    logic [5:0] v [3] = '{6'h3B, 6'h0C, 6'h36};
    logic [2:0] x [3] = '{3'h5, 3'h2, 3'h4};
    for (int k = 0; k < 3; k++) begin
      wr(ad(`IDX_INGRESS_PORT_TYPE_CFG), {26'h0, v[k]});
      repeat (2) @(posedge clk);
      chk({29'h0, tag_dest_en}, {29'h0, x[k]}, "tag destination");
    end
    $display("test tag done");
  endtask : t_tag

  task automatic t_thr();
    wr(ad(`IDX_PORT_MIRRORING_CFG), 32'h00000000);
    wr(ad(`IDX_BROADCAST_THROTTLE_CFG), 32'h00000301);
    rx(2'h0, 3'h0, 1'b0, 1'b1, 11'h40, 2'h3, 5'h00);
    rx(2'h0, 3'h0, 1'b0, 1'b1, 11'h40, 2'h3, 5'h00);
    rx(2'h0, 3'h0, 1'b0, 1'b1, 11'h40, 2'h3, 5'h03);
    rd(ad(`IDX_THROTTLE_STATUS), 32'h00000001);
    rx(2'h0, 3'h0, 1'b0, 1'b0, 11'h40, 2'h3, 5'h00);
    for (int k = 0; k < 3; k++) rx(2'h1, 3'h0, 1'b0, 1'b1, 11'h40, 2'h3, 5'h00);
    repeat (IVL + 5) @(posedge clk);
    rx(2'h0, 3'h0, 1'b0, 1'b1, 11'h40, 2'h3, 5'h00);
    rd(ad(`IDX_THROTTLE_STATUS), 32'h00000000);
    $display("test throttle done");
  endtask : t_thr

  // ============================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0;
    pwdata  = 32'h0;
    rx_pkt  = '0;
    tx_pkt  = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_queue();
    t_regs();
    t_mirror();
    t_tag();
    t_thr();
    print_verdict();
  end
endmodule : switch_queue_mirror_throttle_cfg_tb_top
`default_nettype wire
